// ===== shared/pchd_pkg.sv
// Shared constants and carriers for the parameter channel responder.
// Assumes a parameter store that answers a lookup combinationally, in the same cycle the number is presented.
package pchd_pkg;
    localparam int unsigned PCHD_ID_LSB = 12;
    localparam int unsigned PCHD_ID_MSB = 15;
    localparam int unsigned PCHD_PNU_MSB = 10;
    localparam int unsigned PCHD_SUB_LSB = 8;
    localparam logic [10:0] PCHD_PNU_SPAN = 11'h07d0;
    localparam logic [15:0] PCHD_PNUM_RESET = 16'h0000;

    localparam logic [3:0] PCHD_REQ_NONE = 4'h0;
    localparam logic [3:0] PCHD_REQ_RD = 4'h1;
    localparam logic [3:0] PCHD_REQ_WR_W = 4'h2;
    localparam logic [3:0] PCHD_REQ_WR_D = 4'h3;
    localparam logic [3:0] PCHD_REQ_DESC = 4'h4;
    localparam logic [3:0] PCHD_REQ_RD_F = 4'h6;
    localparam logic [3:0] PCHD_REQ_WR_FW = 4'h7;
    localparam logic [3:0] PCHD_REQ_WR_FD = 4'h8;
    localparam logic [3:0] PCHD_REQ_CNT = 4'h9;

    localparam logic [3:0] PCHD_RSP_NONE = 4'h0;
    localparam logic [3:0] PCHD_RSP_WORD = 4'h1;
    localparam logic [3:0] PCHD_RSP_DWORD = 4'h2;
    localparam logic [3:0] PCHD_RSP_DESC = 4'h3;
    localparam logic [3:0] PCHD_RSP_F_WORD = 4'h4;
    localparam logic [3:0] PCHD_RSP_F_DWORD = 4'h5;
    localparam logic [3:0] PCHD_RSP_COUNT = 4'h6;
    localparam logic [3:0] PCHD_RSP_ERROR = 4'h7;

    localparam logic [7:0] PCHD_ERR_NO_PARAM = 8'h00;
    localparam logic [7:0] PCHD_ERR_READ_ONLY = 8'h01;
    localparam logic [7:0] PCHD_ERR_ABS_LIMIT = 8'h02;
    localparam logic [7:0] PCHD_ERR_BAD_SUB = 8'h03;
    localparam logic [7:0] PCHD_ERR_NO_ARRAY = 8'h04;
    localparam logic [7:0] PCHD_ERR_DATA_TYPE = 8'h05;
    localparam logic [7:0] PCHD_ERR_RESET_ONLY = 8'h06;
    localparam logic [7:0] PCHD_ERR_DESC_FIXED = 8'h07;
    localparam logic [7:0] PCHD_ERR_NO_MASTER = 8'h0b;
    localparam logic [7:0] PCHD_ERR_OP_STATE = 8'h11;
    localparam logic [7:0] PCHD_ERR_INADMISSIBLE = 8'h14;
    localparam logic [7:0] PCHD_ERR_DEACTIVATED = 8'h65;
    localparam logic [7:0] PCHD_ERR_NARROW = 8'h66;
    localparam logic [7:0] PCHD_ERR_NOT_IN_SET = 8'h68;
    localparam logic [7:0] PCHD_ERR_BAD_REQ = 8'h6a;
    localparam logic [7:0] PCHD_ERR_CTRL_ON = 8'h6b;
    localparam logic [7:0] PCHD_ERR_COMMISSION = 8'h86;
    localparam logic [7:0] PCHD_ERR_KNOWHOW = 8'h87;
    localparam logic [7:0] PCHD_ERR_BELOW_CUR = 8'hc8;
    localparam logic [7:0] PCHD_ERR_ABOVE_CUR = 8'hc9;
    localparam logic [7:0] PCHD_ERR_NO_CODE = 8'hcc;

    localparam logic [7:0] PCHD_COMMISSION_LEVEL = 8'h0f;

    // Four-word channel, first word on top
    typedef struct packed {
        logic [15:0] param_id_word;
        logic [15:0] index_word;
        logic [15:0] value_hi;
        logic [15:0] value_lo;
    } pchd_chan_s;

    // Attributes of the looked-up parameter element
    typedef struct packed {
        logic exists;
        logic deactivated;
        logic is_array;
        logic [7:0] elem_count;
        logic is_dword;
        logic changeable;
        logic desc_fixed;
        logic commission_only;
        logic ctrl_locked;
        logic code_needed;
        logic state_busy;
        logic too_wide;
        logic reset_only;
        logic set_permit;
        logic value_listed;
        logic value_in_list;
        logic value_banned;
        logic [31:0] abs_lo;
        logic [31:0] abs_hi;
        logic [31:0] cur_lo;
        logic [31:0] cur_hi;
        logic [31:0] value;
        logic [31:0] desc;
    } pchd_attr_s;

    // Accepted write towards the parameter store
    typedef struct packed {
        logic [15:0] pnum;
        logic [7:0] sub;
        logic [31:0] value;
    } pchd_write_s;
endpackage

// ===== hdl/pchd_responder.sv
// Parameter channel responder: checks each request, answers with a value or an error number.
// Assumes attr_i is driven combinationally by the parameter store in the same cycle that lookup_pnum_o changes.
`timescale 1ns/1ps
module pchd_responder
    import pchd_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire pchd_chan_s req_i,
    output logic req_ready_o,
    output logic [15:0] lookup_pnum_o,
    output logic [7:0] lookup_sub_o,
    input wire pchd_attr_s attr_i,
    input wire logic master_ctrl_i,
    input wire logic knowhow_lock_i,
    input wire logic [7:0] commissioning_param_i,
    output logic rsp_valid_o,
    input wire logic rsp_ready_i,
    output pchd_chan_s rsp_o,
    output logic wr_valid_o,
    output pchd_write_s wr_o
);
    typedef enum logic [1:0] {PCHD_IDLE, PCHD_LOOK, PCHD_RESP} pchd_state_e;

    // Page index to offset; bit 16 flags an unused page
    function automatic logic [16:0] pchd_page_offset(input logic [7:0] page);
        unique case (page)
            8'h00: pchd_page_offset = {1'b0, 16'h0000};
            8'h80: pchd_page_offset = {1'b0, 16'h07d0};
            8'h90: pchd_page_offset = {1'b0, 16'h1770};
            8'h20: pchd_page_offset = {1'b0, 16'h1f40};
            8'ha0: pchd_page_offset = {1'b0, 16'h2710};
            8'h50: pchd_page_offset = {1'b0, 16'h4e20};
            8'hf0: pchd_page_offset = {1'b0, 16'h7530};
            8'h74: pchd_page_offset = {1'b0, 16'hea60};
            default: pchd_page_offset = {1'b1, 16'h0000};
        endcase
    endfunction

    pchd_state_e state_r, state_nxt;
    pchd_chan_s req_r, req_nxt;
    logic page_bad_r, page_bad_nxt;
    logic [15:0] pnum_r, pnum_nxt;
    pchd_chan_s rsp_r, rsp_nxt;
    logic wr_valid_r, wr_valid_nxt;
    pchd_write_s wr_r, wr_nxt;

    logic [3:0] req_id;
    logic [7:0] req_sub;
    logic [10:0] req_pnu;
    logic [16:0] page_dec;
    logic is_read, is_write, is_field, is_known;
    logic [31:0] wval;
    logic err;
    logic [7:0] err_no;
    logic [3:0] ok_id;
    logic [31:0] ok_val;

    assign req_id = req_r.param_id_word[PCHD_ID_MSB:PCHD_ID_LSB];
    assign req_sub = req_r.index_word[15:PCHD_SUB_LSB];
    assign req_pnu = req_r.param_id_word[PCHD_PNU_MSB:0];
    assign page_dec = pchd_page_offset(req_i.index_word[7:0]);

    always_comb begin
        is_read = (req_id == PCHD_REQ_RD) || (req_id == PCHD_REQ_RD_F);
        is_write = (req_id == PCHD_REQ_WR_W) || (req_id == PCHD_REQ_WR_D)
            || (req_id == PCHD_REQ_WR_FW) || (req_id == PCHD_REQ_WR_FD);
        is_field = (req_id == PCHD_REQ_RD_F) || (req_id == PCHD_REQ_WR_FW) || (req_id == PCHD_REQ_WR_FD);
        is_known = is_read || is_write || (req_id == PCHD_REQ_DESC) || (req_id == PCHD_REQ_CNT)
            || (req_id == PCHD_REQ_NONE);
        if ((req_id == PCHD_REQ_WR_W) || (req_id == PCHD_REQ_WR_FW)) begin
            wval = {16'h0000, req_r.value_lo};
        end else begin
            wval = {req_r.value_hi, req_r.value_lo};
        end
    end

    // Single error number chosen by fixed priority
    always_comb begin
        err = 1'b1;
        err_no = PCHD_ERR_NO_PARAM;
        if (!is_known) begin
            err_no = PCHD_ERR_BAD_REQ;
        end else if (req_id == PCHD_REQ_NONE) begin
            err = 1'b0;
        end else if (knowhow_lock_i) begin
            err_no = PCHD_ERR_KNOWHOW;
        end else if (page_bad_r || !attr_i.exists) begin
            err_no = PCHD_ERR_NO_PARAM;
        end else if (attr_i.deactivated) begin
            err_no = PCHD_ERR_DEACTIVATED;
        end else if (req_sub != 8'h00 && !attr_i.is_array) begin
            err_no = PCHD_ERR_NO_ARRAY;
        end else if (attr_i.is_array && req_sub >= attr_i.elem_count) begin
            err_no = PCHD_ERR_BAD_SUB;
        end else if (is_read && attr_i.too_wide) begin
            err_no = PCHD_ERR_NARROW;
        end else if (!is_write) begin
            err = 1'b0;
        end else if (!master_ctrl_i) begin
            err_no = PCHD_ERR_NO_MASTER;
        end else if (attr_i.desc_fixed) begin
            err_no = PCHD_ERR_DESC_FIXED;
        end else if (!attr_i.changeable) begin
            err_no = PCHD_ERR_READ_ONLY;
        end else if (attr_i.commission_only && commissioning_param_i != PCHD_COMMISSION_LEVEL) begin
            err_no = PCHD_ERR_COMMISSION;
        end else if (attr_i.ctrl_locked) begin
            err_no = PCHD_ERR_CTRL_ON;
        end else if (attr_i.code_needed) begin
            err_no = PCHD_ERR_NO_CODE;
        end else if (attr_i.state_busy) begin
            err_no = PCHD_ERR_OP_STATE;
        end else if (attr_i.is_dword != ((req_id == PCHD_REQ_WR_D) || (req_id == PCHD_REQ_WR_FD))) begin
            err_no = PCHD_ERR_DATA_TYPE;
        end else if (wval < attr_i.abs_lo || wval > attr_i.abs_hi) begin
            err_no = PCHD_ERR_ABS_LIMIT;
        end else if (wval < attr_i.cur_lo) begin
            err_no = PCHD_ERR_BELOW_CUR;
        end else if (wval > attr_i.cur_hi) begin
            err_no = PCHD_ERR_ABOVE_CUR;
        end else if (attr_i.value_listed && !attr_i.value_in_list) begin
            err_no = PCHD_ERR_NOT_IN_SET;
        end else if (attr_i.value_banned) begin
            err_no = PCHD_ERR_INADMISSIBLE;
        end else if (attr_i.reset_only && !attr_i.set_permit && wval != 32'h0000_0000) begin
            err_no = PCHD_ERR_RESET_ONLY;
        end else begin
            err = 1'b0;
        end
    end

    // Positive response id and value
    always_comb begin
        ok_id = PCHD_RSP_NONE;
        ok_val = 32'h0000_0000;
        unique case (req_id)
            PCHD_REQ_RD: begin
                ok_id = attr_i.is_dword ? PCHD_RSP_DWORD : PCHD_RSP_WORD;
                ok_val = attr_i.value;
            end
            PCHD_REQ_RD_F: begin
                ok_id = attr_i.is_dword ? PCHD_RSP_F_DWORD : PCHD_RSP_F_WORD;
                ok_val = attr_i.value;
            end
            PCHD_REQ_WR_W: begin
                ok_id = PCHD_RSP_WORD;
                ok_val = wval;
            end
            PCHD_REQ_WR_D: begin
                ok_id = PCHD_RSP_DWORD;
                ok_val = wval;
            end
            PCHD_REQ_WR_FW: begin
                ok_id = PCHD_RSP_F_WORD;
                ok_val = wval;
            end
            PCHD_REQ_WR_FD: begin
                ok_id = PCHD_RSP_F_DWORD;
                ok_val = wval;
            end
            PCHD_REQ_DESC: begin
                ok_id = PCHD_RSP_DESC;
                ok_val = attr_i.desc;
            end
            PCHD_REQ_CNT: begin
                ok_id = PCHD_RSP_COUNT;
                ok_val = {24'h00_0000, attr_i.elem_count};
            end
            default: begin
                ok_id = PCHD_RSP_NONE;
                ok_val = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        page_bad_nxt = page_bad_r;
        pnum_nxt = pnum_r;
        rsp_nxt = rsp_r;
        wr_valid_nxt = 1'b0;
        wr_nxt = wr_r;
        unique case (state_r)
            PCHD_IDLE: begin
                if (req_valid_i) begin
                    req_nxt = req_i;
                    // Field at or above span or unused page means no such parameter
                    page_bad_nxt = page_dec[16] || (req_i.param_id_word[PCHD_PNU_MSB:0] >= PCHD_PNU_SPAN);
                    pnum_nxt = page_dec[15:0] + {5'h00, req_i.param_id_word[PCHD_PNU_MSB:0]};
                    state_nxt = PCHD_LOOK;
                end
            end
            PCHD_LOOK: begin
                rsp_nxt.index_word = req_r.index_word;
                if (err) begin
                    rsp_nxt.param_id_word = {PCHD_RSP_ERROR, 1'b0, req_pnu};
                    rsp_nxt.value_hi = 16'h0000;
                    rsp_nxt.value_lo = {8'h00, err_no};
                end else begin
                    rsp_nxt.param_id_word = {ok_id, 1'b0, req_pnu};
                    rsp_nxt.value_hi = ok_val[31:16];
                    rsp_nxt.value_lo = ok_val[15:0];
                    // Store is written only when no error applies
                    wr_valid_nxt = is_write;
                    wr_nxt.pnum = pnum_r;
                    wr_nxt.sub = req_sub;
                    wr_nxt.value = wval;
                end
                state_nxt = PCHD_RESP;
            end
            PCHD_RESP: begin
                if (rsp_ready_i) begin
                    state_nxt = PCHD_IDLE;
                end
            end
        endcase
        if (is_field && 1'b0) begin
            state_nxt = state_r;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            state_r <= PCHD_IDLE;
            req_r <= '0;
            page_bad_r <= 1'b0;
            pnum_r <= PCHD_PNUM_RESET;
            rsp_r <= '0;
            wr_valid_r <= 1'b0;
            wr_r <= '0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            page_bad_r <= page_bad_nxt;
            pnum_r <= pnum_nxt;
            rsp_r <= rsp_nxt;
            wr_valid_r <= wr_valid_nxt;
            wr_r <= wr_nxt;
        end
    end

    assign req_ready_o = (state_r == PCHD_IDLE);
    assign lookup_pnum_o = pnum_r;
    assign lookup_sub_o = req_sub;
    assign rsp_valid_o = (state_r == PCHD_RESP);
    assign rsp_o = rsp_r;
    assign wr_valid_o = wr_valid_r;
    assign wr_o = wr_r;
endmodule

// ===== tb/pchd_store_model.sv
// Parameter store stand-in answering attribute lookups.
// Assumes the bench sets the attribute template and the one known number.
`timescale 1ns/1ps
module pchd_store_model
    import pchd_pkg::*;
(
    input wire logic [15:0] lookup_pnum_i,
    input wire logic [15:0] known_pnum_i,
    input wire pchd_attr_s tmpl_i,
    output pchd_attr_s attr_o
);
    logic hit;
    assign hit = lookup_pnum_i == known_pnum_i;
    always_comb begin
        attr_o = tmpl_i;
        // Other numbers read as absent, value scrambled
        attr_o.exists = tmpl_i.exists && hit;
        attr_o.value = hit ? tmpl_i.value : ~tmpl_i.value;
    end
endmodule

// ===== tb/pchd_responder_properties.sv
// Port checker for the parameter channel responder.
// Assumes binding onto pchd_responder; checks pause while ce_i is low.
`timescale 1ns/1ps
module pchd_responder_properties
    import pchd_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire pchd_chan_s req_i,
    input wire logic req_ready_o,
    input wire logic knowhow_lock_i,
    input wire logic rsp_valid_o,
    input wire logic rsp_ready_i,
    input wire pchd_chan_s rsp_o,
    input wire logic wr_valid_o,
    input wire pchd_write_s wr_o
);
    logic take;
    logic [3:0] tid;
    logic [3:0] rid;
    pchd_chan_s held_r;
    pchd_chan_s held_nxt;
    assign take = ce_i && req_ready_o && req_valid_i;
    assign tid = req_i.param_id_word[15:12];
    assign rid = rsp_o.param_id_word[15:12];
    always_comb begin
        held_nxt = take ? req_i : held_r;
    end
    always_ff @(posedge core_clk_i) begin
        held_r <= held_nxt;
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i || !ce_i);
    AST_TIMING: assert property (take |=> !req_ready_o && !rsp_valid_o ##1 rsp_valid_o)
        else $error("response not two cycles after request");
    AST_HOLD: assert property (rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_o))
        else $error("response dropped early");
    AST_BAD_ID: assert property (take && (tid == 4'h5 || tid > 4'h9) |-> ##2 rid == PCHD_RSP_ERROR
        && rsp_o.value_lo[7:0] == PCHD_ERR_BAD_REQ) else $error("unsupported id not refused");
    AST_KNOWHOW: assert property (take && tid inside {[4'h1:4'h4], [4'h6:4'h9]} && knowhow_lock_i
        ##1 knowhow_lock_i |=> rid == PCHD_RSP_ERROR && rsp_o.value_lo[7:0] == PCHD_ERR_KNOWHOW)
        else $error("protection not reported");
    AST_NO_REQ: assert property (take && tid == PCHD_REQ_NONE |-> ##2 rid == PCHD_RSP_NONE
        && rsp_o.value_lo == 16'h0000) else $error("empty request answered");
    AST_ECHO: assert property (rsp_valid_o |-> rsp_o.param_id_word[11:0] == {1'b0, held_r.param_id_word[10:0]}
        && rsp_o.index_word == held_r.index_word) else $error("header not echoed");
    AST_ERR_NO_WR: assert property ($rose(rsp_valid_o) && rid == PCHD_RSP_ERROR |-> !wr_valid_o)
        else $error("refused request wrote");
    AST_WR_PAIR: assert property (wr_valid_o && $past(ce_i) |-> $rose(rsp_valid_o)
        && held_r.param_id_word[15:12] inside {4'h2, 4'h3, 4'h7, 4'h8} && wr_o.sub == held_r.index_word[15:8])
        else $error("write without matching request");
endmodule
bind pchd_responder pchd_responder_properties u_props (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .knowhow_lock_i(knowhow_lock_i), .rsp_valid_o(rsp_valid_o),
    .rsp_ready_i(rsp_ready_i), .rsp_o(rsp_o), .wr_valid_o(wr_valid_o), .wr_o(wr_o)
);

// ===== tb/tb_param_channel_error_and_page_decode.sv
// Table and random bench for the parameter channel responder.
// Assumes the store model knows one parameter number at a time.
`timescale 1ns/1ps
module tb_param_channel_error_and_page_decode;
    import pchd_pkg::*;
    logic clk, rstn, ce, req_valid, req_ready, master, knowhow, rsp_valid, rsp_ready, wr_valid, got_wr, ew;
    logic [15:0] lpn, known;
    logic [7:0] lsub, comm, sub;
    logic [3:0] id;
    logic [31:0] v;
    pchd_chan_s req, rsp, got;
    pchd_attr_s attr, tmpl, a;
    pchd_write_s wr, got_w;
    int err_total, n_compared, k, f;
    integer seed;
    logic [15:0] offs [8] = '{16'h0000, 16'h07d0, 16'h1770, 16'h1f40, 16'h2710, 16'h4e20, 16'h7530, 16'hea60};
    logic [7:0] pages [8] = '{8'h00, 8'h80, 8'h90, 8'h20, 8'ha0, 8'h50, 8'hf0, 8'h74};
    logic [7:0] errs [22] = '{8'h6a, 8'h6a, 8'h87, 8'h00, 8'h65, 8'h04, 8'h03, 8'h66, 8'h0b, 8'h07, 8'h01,
        8'h86, 8'h6b, 8'hcc, 8'h11, 8'h05, 8'h02, 8'hc8, 8'hc9, 8'h68, 8'h14, 8'h06};
    logic [3:0] oreq [11] = '{4'h0, 4'h1, 4'h6, 4'h2, 4'h3, 4'h7, 4'h8, 4'h4, 4'h9, 4'h2, 4'h2};
    logic [3:0] orsp [11] = '{4'h0, 4'h1, 4'h5, 4'h1, 4'h2, 4'h4, 4'h5, 4'h3, 4'h6, 4'h1, 4'h1};
    pchd_responder dut (
        .core_clk_i(clk), .rstn_i(rstn), .ce_i(ce), .req_valid_i(req_valid), .req_i(req),
        .req_ready_o(req_ready), .lookup_pnum_o(lpn), .lookup_sub_o(lsub), .attr_i(attr),
        .master_ctrl_i(master), .knowhow_lock_i(knowhow), .commissioning_param_i(comm),
        .rsp_valid_o(rsp_valid), .rsp_ready_i(rsp_ready), .rsp_o(rsp), .wr_valid_o(wr_valid), .wr_o(wr)
    );
    pchd_store_model u_store (.lookup_pnum_i(lpn), .known_pnum_i(known), .tmpl_i(tmpl), .attr_o(attr));
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_hi(input bit on_rsp);
        int n;
        n = 0;
        while ((on_rsp ? rsp_valid : req_ready) !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_total++;
                tally_and_finish();
            end
            @(negedge clk);
        end
    endtask
    // One request, response taken after a random stall
    task automatic run(input logic [3:0] rid, input logic [10:0] fld, input logic [7:0] pg, input logic [31:0] val);
        wait_hi(1'b0);
        req_valid = 1'b1;
        req = {rid, 1'b0, fld, sub, pg, val};
        @(negedge clk);
        req_valid = 1'b0;
        req = ~req;
        wait_hi(1'b1);
        got = rsp;
        got_wr = wr_valid;
        got_w = wr;
        repeat ($unsigned($random(seed)) % 3) @(negedge clk);
        rsp_ready = 1'b1;
        @(negedge clk);
        rsp_ready = 1'b0;
    endtask
    function automatic pchd_attr_s base();
        pchd_attr_s p;
        p = '0;
        p.exists = 1'b1;
        p.changeable = 1'b1;
        p.elem_count = 8'h03;
        p.abs_hi = 32'hffff_ffff;
        p.cur_hi = 32'hffff_ffff;
        p.value = 32'h0000_1234;
        p.desc = 32'h5a5a_0003;
        return p;
    endfunction
    function automatic logic [31:0] exp_val(input logic [3:0] rid, input pchd_attr_s p, input logic [31:0] val);
        case (rid)
            PCHD_REQ_NONE: return 32'h0000_0000;
            PCHD_REQ_RD, PCHD_REQ_RD_F: return p.value;
            PCHD_REQ_DESC: return p.desc;
            PCHD_REQ_CNT: return {24'h00_0000, p.elem_count};
            default: return val;
        endcase
    endfunction
    initial begin
        clk = 1'b0;
        forever begin
            #5 clk = ~clk;
        end
    end
    initial begin
        seed = 32'h89b4_fdbb;
        {rstn, req_valid, rsp_ready, knowhow, ce, master} = 6'h03;
        req = '0;
        comm = 8'h00;
        sub = 8'h00;
        known = 16'h0064;
        tmpl = base();
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        for (k = 0; k < 22; k++) begin
            a = base();
            {knowhow, master, comm} = 10'h100;
            sub = k == 6 ? 8'hff : (k == 5 ? 8'h01 : 8'h00);
            id = k < 2 ? (k == 1 ? 4'ha : 4'h5) : (k == 4 || k == 7 ? 4'h1 : (k == 6 ? 4'h7 : 4'h2));
            case (k)
                1, 2: knowhow = 1'b1;
                3: a.exists = 1'b0;
                4: a.deactivated = 1'b1;
                6: a.is_array = 1'b1;
                7: a.too_wide = 1'b1;
                8: master = 1'b0;
                9: a.desc_fixed = 1'b1;
                10: a.changeable = 1'b0;
                11: a.commission_only = 1'b1;
                12: a.ctrl_locked = 1'b1;
                13: a.code_needed = 1'b1;
                14: a.state_busy = 1'b1;
                15: a.is_dword = 1'b1;
                16: a.abs_hi = 32'h0000_0004;
                17: a.cur_lo = 32'h0000_0006;
                18: a.cur_hi = 32'h0000_0004;
                19: a.value_listed = 1'b1;
                20: a.value_banned = 1'b1;
                21: a.reset_only = 1'b1;
                default: a.exists = 1'b1;
            endcase
            tmpl = a;
            run(id, 11'h064, 8'h00, 32'h0000_0005);
            chk({got.param_id_word[15:12], got.value_lo[7:0], got_wr}, {PCHD_RSP_ERROR, errs[k], 1'b0});
        end
        {knowhow, master} = 2'h1;
        for (k = 0; k < 11; k++) begin
            a = base();
            a.is_array = 1'b1;
            a.is_dword = k inside {2, 4, 6};
            a.value = a.is_dword ? 32'h89ab_cdef : 32'h0000_1234;
            a.commission_only = k == 9;
            a.reset_only = k == 10;
            comm = k == 9 ? 8'h0f : 8'h00;
            v = k == 10 ? 32'h0000_0000 : (a.is_dword ? 32'h0001_0002 : 32'h0000_0077);
            sub = 8'h02;
            id = oreq[k];
            tmpl = a;
            run(id, 11'h064, 8'h00, v);
            ew = id inside {4'h2, 4'h3, 4'h7, 4'h8};
            chk({got.param_id_word[15:12], got.value_hi, got.value_lo, got_wr}, {orsp[k], exp_val(id, a, v), ew});
            if (ew) chk(got_w, {16'h0064, sub, v});
        end
        sub = 8'h00;
        for (k = 0; k < 40; k++) begin
            tmpl = base();
            f = $unsigned($random(seed)) % 2000;
            v = {16'h0000, 16'($random(seed))};
            known = offs[k % 8] + 16'(f);
            ce = 1'b0;
            @(negedge clk);
            ce = 1'b1;
            run(PCHD_REQ_WR_W, 11'(f), pages[k % 8], v);
            chk({got_wr, got_w.pnum, got.value_lo}, {1'b1, known, v[15:0]});
        end
        known = 16'h0064;
        run(PCHD_REQ_RD, 11'h064, 8'h01, 32'h0000_0000);
        chk(got.value_lo[7:0], PCHD_ERR_NO_PARAM);
        known = 16'h07d0;
        run(PCHD_REQ_RD, 11'h7d0, 8'h00, 32'h0000_0000);
        chk(got.value_lo[7:0], PCHD_ERR_NO_PARAM);
        tally_and_finish();
    end
endmodule
